// ### hdl/accc_pkg.sv
// Behaviour
// - Power-off bit 7 removes comparator power.
// - Bit 6 selects bandgap over positive pin.
// - Comparator output synchronised, one-to-two cycle delay.
// - Selected edge event sets flag bit 4.
// - Request needs flag, enable bit 3, global enable.
// - Vector execution clears the flag.
// - Writing one clears flag; zero keeps it.
// - Bit 2 routes comparator to capture front end.
// - Bit 2 clear isolates comparator from capture.
package accc_pkg;
  // Register offset in the I/O space.
  localparam logic [5:0] ACCC_OFS_CTRL = 6'h08;
  // Field positions inside the control and status register.
  localparam int ACCC_BIT_PWR_OFF = 7;
  localparam int ACCC_BIT_BG_SEL = 6;
  localparam int ACCC_BIT_SYNC_OUT = 5;
  localparam int ACCC_BIT_IRQ_FLAG = 4;
  localparam int ACCC_BIT_IRQ_EN = 3;
  localparam int ACCC_BIT_CAP_EN = 2;
  localparam int ACCC_BIT_MODE_HI = 1;
  // Reset value of every control bit.
  localparam logic [7:0] ACCC_CTRL_RST = 8'h00;
  // Interrupt mode encoding; code 01 is reserved and raises no event.
  typedef enum logic [1:0] {
    ACCC_MODE_TOGGLE = 2'b00,
    ACCC_MODE_RSVD = 2'b01,
    ACCC_MODE_FALL = 2'b10,
    ACCC_MODE_RISE = 2'b11
  } accc_mode_t;
endpackage

// ### hdl/accc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for the raw comparator output.
module accc_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  // First stage is read only by the second stage.
  logic meta_r;

  // Both stages reset to zero so the status bit starts defined.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hdl/accc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Control and status logic for the on-chip analog comparator.
module accc_top
  import accc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic comp_raw,
  input wire logic global_irq_en,
  input wire logic irq_vector_ack,
  output logic comparator_power_off,
  output logic bandgap_select,
  output logic capture_trigger,
  output logic comparator_irq_req
);
  // Control bits held by software.
  logic pwr_off_r;
  logic bg_sel_r;
  logic irq_en_r;
  logic cap_en_r;
  logic [1:0] mode_r;
  // Hardware-set interrupt flag.
  logic irq_flag_r;
  logic irq_flag_nxt;
  // Synchronised comparator output and its previous value.
  logic comparator_sync_output;
  logic sync_prev_r;
  logic evt;
  logic wr_hit;

  // Decode shared by read and write paths.
  function automatic logic addr_hit(input logic [5:0] a);
    return a == ACCC_OFS_CTRL;
  endfunction

  assign wr_hit = io_wr && addr_hit(io_addr);

  // Raw comparator crosses into the clock domain here.
  accc_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(comp_raw),
    .sync_out(comparator_sync_output)
  );

  // Control bits; the status bit position is not stored, so writes to it vanish.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {pwr_off_r, bg_sel_r} <= 2'h0;
      irq_en_r <= 1'b0;
      cap_en_r <= 1'b0;
      mode_r <= 2'h0;
    end else if (wr_hit) begin
      pwr_off_r <= io_wdata[ACCC_BIT_PWR_OFF];
      bg_sel_r <= io_wdata[ACCC_BIT_BG_SEL];
      irq_en_r <= io_wdata[ACCC_BIT_IRQ_EN];
      cap_en_r <= io_wdata[ACCC_BIT_CAP_EN];
      mode_r <= io_wdata[ACCC_BIT_MODE_HI -: 2];
    end
  end

  // Previous synchronised value for edge detection.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_prev_r <= 1'b0;
    end else begin
      sync_prev_r <= comparator_sync_output;
    end
  end

  // Event selection from the mode field.
  always_comb begin
    unique case (accc_mode_t'(mode_r))
      ACCC_MODE_TOGGLE: evt = comparator_sync_output ^ sync_prev_r;
      ACCC_MODE_FALL: evt = sync_prev_r & ~comparator_sync_output;
      ACCC_MODE_RISE: evt = comparator_sync_output & ~sync_prev_r;
      default: evt = 1'b0;
    endcase
  end

  // Flag: a new event wins over a clear in the same cycle.
  always_comb begin
    irq_flag_nxt = irq_flag_r;
    if (irq_vector_ack) begin
      irq_flag_nxt = 1'b0;
    end
    if (wr_hit && io_wdata[ACCC_BIT_IRQ_FLAG]) begin
      irq_flag_nxt = 1'b0;
    end
    if (evt) begin
      irq_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_flag_r <= 1'b0;
    end else begin
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // Registered outputs; the request is masked by both enables.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      comparator_irq_req <= 1'b0;
      capture_trigger <= 1'b0;
      comparator_power_off <= 1'b0;
      bandgap_select <= 1'b0;
    end else begin
      comparator_irq_req <= irq_flag_nxt && irq_en_r && global_irq_en;
      // Gated so nothing reaches the capture front end when disabled.
      capture_trigger <= cap_en_r && comparator_sync_output;
      comparator_power_off <= pwr_off_r;
      bandgap_select <= bg_sel_r;
    end
  end

  // Read data; unmapped addresses read zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= ACCC_CTRL_RST;
    end else if (io_rd && addr_hit(io_addr)) begin
      io_rdata <= {pwr_off_r, bg_sel_r, comparator_sync_output, irq_flag_r,
                   irq_en_r, cap_en_r, mode_r};
    end else begin
      io_rdata <= 8'h00;
    end
  end

  // Request follows flag and enables one cycle later.
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    comparator_irq_req == $past(irq_flag_nxt && irq_en_r && global_irq_en))
    else $error("irq request mismatch");
  // A rising event in rise mode sets the flag next cycle.
  a_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_r == ACCC_MODE_RISE && comparator_sync_output && !sync_prev_r) |=> irq_flag_r)
    else $error("flag not set");
  // Write-one clears when no event.
  a_flag_w1c: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_hit && io_wdata[ACCC_BIT_IRQ_FLAG] && !evt) |=> !irq_flag_r)
    else $error("flag not cleared");
  // Vector acknowledge clears when no event.
  a_flag_ack: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_vector_ack && !evt) |=> !irq_flag_r)
    else $error("ack did not clear");
  // Zero write keeps a set flag.
  a_flag_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_flag_r && wr_hit && !io_wdata[ACCC_BIT_IRQ_FLAG] && !irq_vector_ack) |=> irq_flag_r)
    else $error("flag lost");
  // Raw input visible two cycles later.
  a_sync_lat: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##2 comparator_sync_output == $past(comp_raw, 2))
    else $error("sync latency wrong");
  // No capture path when routing is off.
  a_cap_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(cap_en_r) |-> !capture_trigger)
    else $error("capture leaked");
  // Power-off written reaches the pin two cycles after the write.
  a_pwr_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_hit |=> ##1 comparator_power_off == $past(io_wdata[ACCC_BIT_PWR_OFF], 2))
    else $error("power off wrong");
  // Bandgap select follows the write the same way.
  a_bg_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_hit |=> ##1 bandgap_select == $past(io_wdata[ACCC_BIT_BG_SEL], 2))
    else $error("bandgap select wrong");

  // Sequences shared by the edge properties below; each spans two samples of the status bit.
  // A rising step of the synchronised output.
  sequence s_sync_rise;
    !comparator_sync_output ##1 comparator_sync_output;
  endsequence
  // A falling step of the synchronised output.
  sequence s_sync_fall;
    comparator_sync_output ##1 !comparator_sync_output;
  endsequence

  // A falling step in falling mode sets the flag next cycle.
  a_fall_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_sync_fall ##0 (mode_r == ACCC_MODE_FALL)) |=> irq_flag_r)
    else $error("fall did not set flag");
  // Either step in toggle mode sets the flag next cycle.
  a_toggle_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((s_sync_rise or s_sync_fall) ##0 (mode_r == ACCC_MODE_TOGGLE)) |=> irq_flag_r)
    else $error("toggle did not set flag");
  // The reserved mode code never raises an event.
  a_rsvd_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_r == ACCC_MODE_RSVD) |-> !evt)
    else $error("reserved mode raised event");
  // A register read returns the synchronised status in its own bit.
  a_rd_status: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_rd && addr_hit(io_addr)) |=> io_rdata[ACCC_BIT_SYNC_OUT] == $past(comparator_sync_output))
    else $error("status bit read wrong");
  // Reads of other addresses return zero.
  a_rd_other: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_rd && !addr_hit(io_addr)) |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  // A cleared local enable masks the request.
  a_req_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !irq_en_r |=> !comparator_irq_req)
    else $error("masked request raised");
  // With routing on, a high status bit reaches the capture front end.
  a_cap_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cap_en_r && comparator_sync_output) |=> capture_trigger)
    else $error("capture route missing");
  // The mode field only changes on a register write.
  a_mode_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !wr_hit |=> $stable(mode_r))
    else $error("mode changed without write");
  // A set flag stays set while nothing clears it.
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_flag_r && !irq_vector_ack && !(wr_hit && io_wdata[ACCC_BIT_IRQ_FLAG])) |=> irq_flag_r)
    else $error("flag dropped");
endmodule
`default_nettype wire

// ### sim/accc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Behavioural comparator core; an unpowered core rests low, so no edge reaches the block while power stays off.
module accc_core_model (
  input wire logic power_off,
  input wire logic bg_sel,
  input wire logic pin_above,
  input wire logic bg_above,
  output logic comp_out
);
  // Reference choice first, then power gating.
  assign comp_out = !power_off && (bg_sel ? bg_above : pin_above);
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Register-level bench for the comparator control block.
module tb;
  import accc_pkg::*;
  `define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic global_irq_en = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic pin_above = 1'b0;
  logic comp_raw, pwr_off, bg_sel, cap_trig, irq_req;
  int error_cnt = 0;
  int tests_run = 0;
  // Expected flag after a rise and after a fall, indexed by mode code.
  logic [1:0] exp_ev [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
  // Free-running system clock.
  always #20 clk_sys = ~clk_sys;
  accc_core_model core (.power_off(pwr_off), .bg_sel(bg_sel), .pin_above(pin_above), .bg_above(1'b1),
    .comp_out(comp_raw));
  accc_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .comp_raw(comp_raw), .global_irq_en(global_irq_en),
    .irq_vector_ack(irq_vector_ack), .comparator_power_off(pwr_off), .bandgap_select(bg_sel),
    .capture_trigger(cap_trig), .comparator_irq_req(irq_req));
  // One-cycle write, then wait until the control outputs have settled.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys) io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys) io_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // One-cycle read; the registered answer is looked at just after the taking edge.
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys) io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys) io_rd <= 1'b0;
    #1 `CHK("io_rdata", e, io_rdata)
  endtask
  // Move the pin and allow time for synchroniser and flag.
  task automatic comp(input logic v);
    @(posedge clk_sys) pin_above <= v;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ACCC_OFS_CTRL, ACCC_CTRL_RST);
    wr(ACCC_OFS_CTRL, 8'hE7); // Interrupt stays masked across the power change
    `CHK("power_off", 1'b1, pwr_off)
    `CHK("bandgap", 1'b1, bg_sel)
    rd(ACCC_OFS_CTRL, 8'hC7);
    wr(6'h09, 8'h00);
    rd(6'h09, 8'h00);
    rd(ACCC_OFS_CTRL, 8'hC7);
    wr(ACCC_OFS_CTRL, 8'h00);
    `CHK("power_off", 1'b0, pwr_off)
    for (int m = 0; m < 4; m++) begin
      wr(ACCC_OFS_CTRL, 8'h10 | 8'(m));
      comp(1'b1);
      rd(ACCC_OFS_CTRL, {2'b00, 1'b1, exp_ev[m][1], 2'b00, 2'(m)});
      wr(ACCC_OFS_CTRL, 8'h10 | 8'(m));
      comp(1'b0);
      rd(ACCC_OFS_CTRL, {3'b000, exp_ev[m][0], 2'b00, 2'(m)});
    end
    wr(ACCC_OFS_CTRL, 8'h13);
    comp(1'b1);
    wr(ACCC_OFS_CTRL, 8'h0B);
    `CHK("irq_req", 1'b0, irq_req)
    @(posedge clk_sys) global_irq_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("irq_req", 1'b1, irq_req)
    wr(ACCC_OFS_CTRL, 8'h03);
    `CHK("irq_req", 1'b0, irq_req)
    rd(ACCC_OFS_CTRL, 8'h33);
    wr(ACCC_OFS_CTRL, 8'h0B);
    `CHK("irq_req", 1'b1, irq_req)
    @(posedge clk_sys) irq_vector_ack <= 1'b1;
    @(posedge clk_sys) irq_vector_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("irq_req", 1'b0, irq_req)
    rd(ACCC_OFS_CTRL, 8'h2B);
    wr(ACCC_OFS_CTRL, 8'h07);
    `CHK("capture", 1'b1, cap_trig)
    wr(ACCC_OFS_CTRL, 8'h03);
    `CHK("capture", 1'b0, cap_trig)
    report_and_stop;
  end
endmodule
`default_nettype wire
